// *** core/hub_rep_pkg.sv ***
// Shared constants for the hub repeater connectivity block and its descriptor store.
// Assumes one 10 MHz system clock and an 8-bit register port.
package hub_rep_pkg;

    // ------------------------------------------------------------
    // Ports and clock
    // ------------------------------------------------------------
    localparam int          NUM_DN          = 5;       // Ports 1..5 downstream
    localparam int          CLK_PERIOD_NS   = 100;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_HUB_ADDR   = 8'h97;
    localparam logic [7:0]  ADDR_DESC_SEL   = 8'h98;
    localparam logic [7:0]  ADDR_DESC_OFF   = 8'h99;
    localparam logic [7:0]  ADDR_DESC_DATA  = 8'h9A;
    localparam logic [7:0]  ADDR_LINK_STAT  = 8'h9B;
    localparam logic [7:0]  HUB_ADDR_RST    = 8'h00;
    localparam int          HUB_ADDR_W      = 7;       // Bit 7 reserved
    localparam logic [2:0]  DESC_SEL_RST    = 3'h0;
    localparam logic [4:0]  DESC_OFF_RST    = 5'h00;
    localparam logic [4:0]  DESC_OFF_STEP   = 5'h01;
    localparam logic [7:0]  RDATA_RST       = 8'h00;

    // ------------------------------------------------------------
    // Descriptor set
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DESC_DEVICE, DESC_CONFIG, DESC_IFACE, DESC_ENDPT, DESC_HUB
    } desc_kind_e;

    localparam logic [7:0]  LEN_DEVICE      = 8'h12;   // 18 bytes
    localparam logic [7:0]  LEN_CONFIG      = 8'h09;
    localparam logic [7:0]  LEN_IFACE       = 8'h09;
    localparam logic [7:0]  LEN_ENDPT       = 8'h07;
    localparam logic [7:0]  LEN_HUB         = 8'h09;
    localparam logic [7:0]  TYPE_DEVICE     = 8'h01;
    localparam logic [7:0]  TYPE_CONFIG     = 8'h02;
    localparam logic [7:0]  TYPE_IFACE      = 8'h04;
    localparam logic [7:0]  TYPE_ENDPT      = 8'h05;
    localparam logic [7:0]  TYPE_HUB        = 8'h29;
    localparam logic [7:0]  NUM_CONFIGS     = 8'h01;
    localparam logic [7:0]  NUM_IFACES      = 8'h01;
    localparam logic [7:0]  NUM_ENDPTS      = 8'h01;   // Endpoint 0 not counted

    // Byte offsets inside the descriptors: common, hub, then device, configuration and interface counts
    localparam logic [4:0]  OFS_LENGTH      = 5'h00;
    localparam logic [4:0]  OFS_TYPE        = 5'h01;
    localparam logic [4:0]  OFS_NPORTS      = 5'h02;
    localparam logic [4:0]  OFS_CHAR_LO     = 5'h03;
    localparam logic [4:0]  OFS_CHAR_HI     = 5'h04;
    localparam logic [4:0]  OFS_PWR_GOOD    = 5'h05;
    localparam logic [4:0]  OFS_CTRL_CUR    = 5'h06;
    localparam logic [4:0]  OFS_REMOVABLE   = 5'h07;
    localparam logic [4:0]  OFS_PWR_MASK    = 5'h08;   // First byte after removable
    localparam logic [4:0]  OFS_DEV_NCFG    = 5'h11;   // Last device byte
    localparam logic [4:0]  OFS_CFG_NIF     = 5'h04;
    localparam logic [4:0]  OFS_IF_NEP      = 5'h04;

endpackage : hub_rep_pkg

// *** core/hub_descriptor_rom.sv ***
// Descriptor store for the hub: five descriptors, one byte read per cycle.
// Assumes the caller presents the next address; data appear registered one edge later.
`timescale 1ns/10ps
module hub_descriptor_rom #(
    parameter logic [7:0] HUB_CHAR_LO   = 8'h00,
    parameter logic [7:0] HUB_CHAR_HI   = 8'h00,
    parameter logic [7:0] PWR_GOOD_2MS  = 8'h00,
    parameter logic [7:0] CTRL_CURRENT  = 8'h00,
    parameter logic [7:0] REMOVABLE     = 8'h00,
    parameter logic [7:0] PWR_MASK      = 8'h00
) (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    // Read address
    input  wire logic [2:0] i_sel,
    input  wire logic [4:0] i_off,
    // Read data
    output logic [7:0]      o_data
);

    // ------------------------------------------------------------
    // Contents
    // ------------------------------------------------------------
    // Bytes past a descriptor's end read as zero; identity bytes stay zero (arbitrary)
    function automatic logic [7:0] rom_byte(input logic [2:0] sel, input logic [4:0] off);
        logic [7:0] len;
        logic [7:0] typ;
        logic [7:0] b;
        len = 8'h00;
        typ = 8'h00;
        b   = 8'h00;
        case (sel)
            hub_rep_pkg::DESC_DEVICE: begin
                len = hub_rep_pkg::LEN_DEVICE;
                typ = hub_rep_pkg::TYPE_DEVICE;
                if (off == hub_rep_pkg::OFS_DEV_NCFG) b = hub_rep_pkg::NUM_CONFIGS;
            end
            hub_rep_pkg::DESC_CONFIG: begin
                len = hub_rep_pkg::LEN_CONFIG;
                typ = hub_rep_pkg::TYPE_CONFIG;
                if (off == hub_rep_pkg::OFS_CFG_NIF) b = hub_rep_pkg::NUM_IFACES;
            end
            hub_rep_pkg::DESC_IFACE: begin
                len = hub_rep_pkg::LEN_IFACE;
                typ = hub_rep_pkg::TYPE_IFACE;
                if (off == hub_rep_pkg::OFS_IF_NEP) b = hub_rep_pkg::NUM_ENDPTS;
            end
            hub_rep_pkg::DESC_ENDPT: begin
                len = hub_rep_pkg::LEN_ENDPT;
                typ = hub_rep_pkg::TYPE_ENDPT;
            end
            hub_rep_pkg::DESC_HUB: begin
                len = hub_rep_pkg::LEN_HUB;
                typ = hub_rep_pkg::TYPE_HUB;
                case (off)
                    hub_rep_pkg::OFS_NPORTS:    b = 8'(hub_rep_pkg::NUM_DN);
                    hub_rep_pkg::OFS_CHAR_LO:   b = HUB_CHAR_LO;
                    hub_rep_pkg::OFS_CHAR_HI:   b = HUB_CHAR_HI;
                    hub_rep_pkg::OFS_PWR_GOOD:  b = PWR_GOOD_2MS;
                    hub_rep_pkg::OFS_CTRL_CUR:  b = CTRL_CURRENT;
                    hub_rep_pkg::OFS_REMOVABLE: b = REMOVABLE;
                    hub_rep_pkg::OFS_PWR_MASK:  b = PWR_MASK;
                    default:                    b = 8'h00;
                endcase
            end
            default: begin
                len = 8'h00;
            end
        endcase
        if (off == hub_rep_pkg::OFS_LENGTH) b = len;
        if (off == hub_rep_pkg::OFS_TYPE) b = typ;
        if ({3'h0, off} >= len) b = 8'h00;
        return b;
    endfunction : rom_byte

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_data <= hub_rep_pkg::RDATA_RST;
        end else begin
            o_data <= rom_byte(i_sel, i_off);
        end
    end

endmodule : hub_descriptor_rom

// *** core/hub_repeater_connectivity.sv ***
// Per-packet connectivity of the hub repeater, hub address register and descriptor access.
// Assumes packet markers from the serial interface engine, one cycle wide, synchronous.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps

// Overview of operation
// - Root start of packet connects root to every enabled full-speed port
// - Full-speed downstream packets never reach enabled low-speed ports
// - End of packet tears the connection down to idle, both directions
// - Downstream start of packet connects exactly that port upstream
// - Simultaneous downstream starts: only one port is chosen
// - Low-speed downstream packets reach all enabled ports
// - Preamble seen by the serial engine adds the enabled low-speed ports
// - Data is inverted at low-speed ports, both directions
// - No preamble is sent ahead of upstream low-speed packets
// - Upstream low-speed packets leave the root port at full-speed edges
// - Unenumerated hub holds hub address zero
// - Hub address resets to zero; bit 7 reserved, low bits hold address
// - Five descriptors of 18, 9, 9, 7 and 9 bytes
// - No endpoint 0 descriptor; one configuration and one interface
// - Hub descriptor bytes laid out at their fixed offsets, mask follows
// - Token addresses are compared with the hub address register
// - Only enabled downstream ports take part in packet connections
// - Port 0 is root, port 1 internal, ports 2 to 5 external
module hub_repeater_connectivity #(
    parameter int NDN = hub_rep_pkg::NUM_DN
) (
    // Clock and reset
    input  wire logic           i_clk_sys,
    input  wire logic           i_resetn,
    // Root port packet markers
    input  wire logic           i_root_sop,
    input  wire logic           i_root_eop,
    input  wire logic           i_root_pre,
    // Downstream port markers and state, bit 0 is port 1
    input  wire logic [NDN-1:0] i_dn_sop,
    input  wire logic [NDN-1:0] i_dn_eop,
    input  wire logic [NDN-1:0] i_port_enabled,
    input  wire logic [NDN-1:0] i_port_low_speed,
    // Token address from the hub interface unit
    input  wire logic           i_tok_valid,
    input  wire logic [6:0]     i_tok_addr,
    // Register port
    input  wire logic [7:0]     i_reg_addr,
    input  wire logic [7:0]     i_reg_wdata,
    input  wire logic           i_reg_wr,
    input  wire logic           i_reg_rd,
    output logic [7:0]          o_reg_rdata,
    // Connectivity
    output logic [NDN-1:0]      o_dn_connect,
    output logic [NDN-1:0]      o_dn_invert,
    output logic [NDN-1:0]      o_up_select,
    output logic                o_up_active,
    output logic                o_up_invert,
    output logic                o_up_fs_edge,
    // Token decode
    output logic                o_tok_match
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_DOWN, ST_UP} link_state_e;

    typedef struct packed {
        link_state_e    state;
        logic [NDN-1:0] dn_conn;
        logic [NDN-1:0] dn_inv;
        logic [NDN-1:0] up_sel;
        logic           up_act;
        logic           up_inv;
        logic           up_fs;
        logic           ls_pkt;
        logic [6:0]     haddr;
        logic [2:0]     desc_sel;
        logic [4:0]     desc_off;
        logic [7:0]     rdata;
        logic           tok_match;
    } hub_state_s;

    hub_state_s s_q;
    hub_state_s s_d;
    logic [7:0] rom_data;

    // Lowest-numbered requester wins; keeps a collision deterministic
    function automatic logic [NDN-1:0] pick_one(input logic [NDN-1:0] req);
        logic [NDN-1:0] g;
        g = '0;
        for (int i = NDN - 1; i >= 0; i--) begin
            if (req[i]) g = '0;
            if (req[i]) g[i] = 1'b1;
        end
        return g;
    endfunction : pick_one

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        case (s_q.state)
            ST_IDLE: begin
                s_d.dn_conn = '0;
                s_d.dn_inv  = '0;
                s_d.up_sel  = '0;
                s_d.up_act  = 1'b0;
                s_d.up_inv  = 1'b0;
                s_d.up_fs   = 1'b0;
                s_d.ls_pkt  = 1'b0;
                // Root traffic first: the host owns the bus
                if (i_root_sop) begin
                    s_d.state   = ST_DOWN;
                    s_d.dn_conn = i_port_enabled & ~i_port_low_speed;
                end else if (|(i_dn_sop & i_port_enabled)) begin
                    s_d.state  = ST_UP;
                    s_d.up_sel = pick_one(i_dn_sop & i_port_enabled);
                    s_d.up_act = 1'b1;
                    // Root never emits a preamble upstream, only the packet
                    s_d.up_inv = |(s_d.up_sel & i_port_low_speed);
                    s_d.up_fs  = 1'b1;
                end
            end
            ST_DOWN: begin
                if (i_root_pre && !s_q.ls_pkt) begin
                    s_d.ls_pkt  = 1'b1;
                    s_d.dn_conn = i_port_enabled;
                    s_d.dn_inv  = i_port_enabled & i_port_low_speed;
                end else begin
                    // Ports leaving the enabled state drop out at once
                    s_d.dn_conn = s_q.dn_conn & i_port_enabled;
                    s_d.dn_inv  = s_q.dn_inv & i_port_enabled;
                end
                if (i_root_eop) begin
                    s_d.state   = ST_IDLE;
                    s_d.dn_conn = '0;
                    s_d.dn_inv  = '0;
                    s_d.ls_pkt  = 1'b0;
                end
            end
            ST_UP: begin
                if (|(i_dn_eop & s_q.up_sel) || !(|(s_q.up_sel & i_port_enabled))) begin
                    s_d.state  = ST_IDLE;
                    s_d.up_sel = '0;
                    s_d.up_act = 1'b0;
                    s_d.up_inv = 1'b0;
                    s_d.up_fs  = 1'b0;
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase

        // Token ownership
        s_d.tok_match = i_tok_valid && (i_tok_addr == s_q.haddr);

        // Register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                hub_rep_pkg::ADDR_HUB_ADDR:
                    s_d.haddr = i_reg_wdata[hub_rep_pkg::HUB_ADDR_W-1:0];
                hub_rep_pkg::ADDR_DESC_SEL: s_d.desc_sel = i_reg_wdata[2:0];
                hub_rep_pkg::ADDR_DESC_OFF: s_d.desc_off = i_reg_wdata[4:0];
                default: ;
            endcase
        end

        // Register reads; descriptor data steps the offset for streaming
        s_d.rdata = s_q.rdata;
        if (i_reg_rd) begin
            case (i_reg_addr)
                hub_rep_pkg::ADDR_HUB_ADDR:  s_d.rdata = {1'b0, s_q.haddr};
                hub_rep_pkg::ADDR_DESC_SEL:  s_d.rdata = {5'h00, s_q.desc_sel};
                hub_rep_pkg::ADDR_DESC_OFF:  s_d.rdata = {3'h0, s_q.desc_off};
                hub_rep_pkg::ADDR_DESC_DATA: begin
                    s_d.rdata    = rom_data;
                    s_d.desc_off = s_q.desc_off + hub_rep_pkg::DESC_OFF_STEP;
                end
                hub_rep_pkg::ADDR_LINK_STAT: s_d.rdata = {5'h00, s_q.ls_pkt,
                                                          s_q.state};
                default:                     s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            s_q.state     <= ST_IDLE;
            s_q.dn_conn   <= '0;
            s_q.dn_inv    <= '0;
            s_q.up_sel    <= '0;
            s_q.up_act    <= 1'b0;
            s_q.up_inv    <= 1'b0;
            s_q.up_fs     <= 1'b0;
            s_q.ls_pkt    <= 1'b0;
            s_q.haddr     <= hub_rep_pkg::HUB_ADDR_RST[6:0];
            s_q.desc_sel  <= hub_rep_pkg::DESC_SEL_RST;
            s_q.desc_off  <= hub_rep_pkg::DESC_OFF_RST;
            s_q.rdata     <= hub_rep_pkg::RDATA_RST;
            s_q.tok_match <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Descriptor store
    // ------------------------------------------------------------
    // Fed with next pointer so a read right after a pointer write sees fresh data
    hub_descriptor_rom u_desc (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_sel     (s_d.desc_sel),
        .i_off     (s_d.desc_off),
        .o_data    (rom_data)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_dn_connect = s_q.dn_conn;
    assign o_dn_invert  = s_q.dn_inv;
    assign o_up_select  = s_q.up_sel;
    assign o_up_active  = s_q.up_act;
    assign o_up_invert  = s_q.up_inv;
    assign o_up_fs_edge = s_q.up_fs;
    assign o_tok_match  = s_q.tok_match;
    assign o_reg_rdata  = s_q.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    AST_ROOT_CONNECT_FS: assert property (
        (s_q.state == ST_IDLE && i_root_sop)
        |=> (o_dn_connect == ($past(i_port_enabled) & ~$past(i_port_low_speed))))
        else $error("root start did not connect enabled full-speed ports");

    AST_NO_LS_BEFORE_PRE: assert property (
        (s_q.state == ST_DOWN && !s_q.ls_pkt) |-> ((o_dn_connect & i_port_low_speed) == '0
            || $changed(i_port_low_speed)))
        else $error("low-speed port connected for full-speed packet");

    AST_EOP_TEARDOWN: assert property (
        (s_q.state == ST_DOWN && i_root_eop) |=> (o_dn_connect == '0 && s_q.state == ST_IDLE))
        else $error("end of packet did not tear down downstream path");

    AST_UP_ONE_HOT: assert property (
        o_up_active |-> $onehot(o_up_select))
        else $error("upstream selection is not exactly one port");

    AST_UP_LOWEST_WINS: assert property (
        (s_q.state == ST_IDLE && !i_root_sop && |(i_dn_sop & i_port_enabled))
        |=> (o_up_select == pick_one($past(i_dn_sop) & $past(i_port_enabled))))
        else $error("collision did not resolve to a single port");

    AST_PRE_ALL_ENABLED: assert property (
        (s_q.state == ST_DOWN && !s_q.ls_pkt && i_root_pre && !i_root_eop)
        |=> (o_dn_connect == $past(i_port_enabled) && s_q.ls_pkt))
        else $error("preamble did not connect all enabled ports");

    AST_UP_FS_EDGES: assert property (
        o_up_active == o_up_fs_edge)
        else $error("upstream not using full-speed edges");

    AST_HADDR_WRITE: assert property (
        (i_reg_wr && i_reg_addr == hub_rep_pkg::ADDR_HUB_ADDR)
        ##1 (i_reg_rd && i_reg_addr == hub_rep_pkg::ADDR_HUB_ADDR)
        |=> (o_reg_rdata == {1'b0, $past(i_reg_wdata[hub_rep_pkg::HUB_ADDR_W-1:0], 2)}))
        else $error("hub address readback wrong");

    AST_IDLE_QUIET: assert property (
        (s_q.state == ST_IDLE) |-> (o_dn_connect == '0 && !o_up_active))
        else $error("connection open while idle");

endmodule : hub_repeater_connectivity

// *** testbench/host_root_model.sv ***
// Host controller model on the root port: start, preamble and end of packet markers.
// Assumes calls start right after a rising edge; each marker stands for one cycle.
`timescale 1ns/10ps
module host_root_model (
    // Clock
    input  wire logic i_clk_sys,
    // Root port markers
    output logic      o_sop,
    output logic      o_pre,
    output logic      o_eop
);
    // ------------------------------------------------------------
    // Marker strobes
    // ------------------------------------------------------------
    initial begin
        o_sop = 1'b0;
        o_pre = 1'b0;
        o_eop = 1'b0;
    end

    // Kind 0 start, 1 preamble, 2 end; the edge after the strobe clears it again
    task automatic pulse(input int kind);
        @(posedge i_clk_sys);
        o_sop <= (kind == 0);
        o_pre <= (kind == 1);
        o_eop <= (kind == 2);
        @(posedge i_clk_sys);
        o_sop <= 1'b0;
        o_pre <= 1'b0;
        o_eop <= 1'b0;
    endtask : pulse
endmodule : host_root_model

// *** testbench/hub_repeater_connectivity_tb_top.sv ***
// Self-checking bench for the hub repeater connectivity block.
// Assumes the root host model drives the root markers; the bench acts as firmware.
`timescale 1ns/10ps
module hub_repeater_connectivity_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk_sys, resetn, root_sop, root_eop, root_pre, tok_valid, reg_wr, reg_rd;
    logic [4:0] dn_sop, dn_eop, port_enabled, port_low_speed, dn_connect, dn_invert, up_select;
    logic [6:0] tok_addr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic       up_active, up_invert, up_fs_edge, tok_match;
    int         err_total = 0;
    int         checked   = 0;

    hub_repeater_connectivity u_hub_repeater_connectivity (
        .i_clk_sys(clk_sys), .i_resetn(resetn), .i_root_sop(root_sop), .i_root_eop(root_eop),
        .i_root_pre(root_pre), .i_dn_sop(dn_sop), .i_dn_eop(dn_eop),
        .i_port_enabled(port_enabled), .i_port_low_speed(port_low_speed),
        .i_tok_valid(tok_valid), .i_tok_addr(tok_addr), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
        .o_dn_connect(dn_connect), .o_dn_invert(dn_invert), .o_up_select(up_select),
        .o_up_active(up_active), .o_up_invert(up_invert), .o_up_fs_edge(up_fs_edge),
        .o_tok_match(tok_match));

    host_root_model u_host_root_model (
        .i_clk_sys(clk_sys), .o_sop(root_sop), .o_pre(root_pre), .o_eop(root_eop));

    // ------------------------------------------------------------
    // Clock, closing and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #(hub_rep_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Whole run is about a hundred cycles; thirty times that means a hang
    initial begin
        #(hub_rep_pkg::CLK_PERIOD_NS * 3000);
        err_total++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // Read data stand from the cycle after the strobe until the next read; they are taken there
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Write and read strobes back to back, no idle cycle between them
    task automatic reg_write_read(input logic [7:0] a, input logic [7:0] d,
                                  output logic [7:0] q);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        #1 q = reg_rdata;
    endtask : reg_write_read

    task automatic token(input logic [6:0] a, input logic exp);
        @(posedge clk_sys);
        tok_addr  <= a;
        tok_valid <= 1'b1;
        @(posedge clk_sys);
        tok_valid <= 1'b0;
        #1 cmp("tok_match", {7'h00, exp}, {7'h00, tok_match});
        @(posedge clk_sys);
        #1 cmp("tok_match_end", 8'h00, {7'h00, tok_match});
    endtask : token

    task automatic dn_mark(input logic [4:0] s, input logic [4:0] e);
        @(posedge clk_sys);
        dn_sop <= s;
        dn_eop <= e;
        @(posedge clk_sys);
        dn_sop <= 5'h00;
        dn_eop <= 5'h00;
        #1;
    endtask : dn_mark

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_address();
        reg_read(8'h97, rd_val);
        cmp("addr_reset", 8'h00, rd_val);
        reg_write_read(8'h97, 8'hFA, rd_val);
        cmp("addr_back_to_back", 8'h7A, rd_val);
        reg_write(8'h97, 8'h85);
        reg_write(8'h10, 8'h33);
        reg_read(8'h97, rd_val);
        cmp("addr_bit7_reserved", 8'h05, rd_val);
        reg_read(8'h10, rd_val);
        cmp("unmapped_read", 8'h00, rd_val);
        token(7'h05, 1'b1);
        token(7'h06, 1'b0);
    endtask : test_address

    // Port 1 disabled, ports 1 and 2 low speed, ports 3 to 5 full speed
    task automatic test_downstream();
        cmp("idle_connect", 8'h00, {3'h0, dn_connect});
        u_host_root_model.pulse(0);
        #1 cmp("fs_connect", 8'h1C, {3'h0, dn_connect});
        cmp("fs_invert", 8'h00, {3'h0, dn_invert});
        u_host_root_model.pulse(1);
        #1 cmp("ls_connect", 8'h1E, {3'h0, dn_connect});
        cmp("ls_invert", 8'h02, {3'h0, dn_invert});
        cmp("no_up_path", 8'h00, {7'h00, up_active});
        u_host_root_model.pulse(2);
        #1 cmp("eop_connect", 8'h00, {3'h0, dn_connect});
        cmp("eop_invert", 8'h00, {3'h0, dn_invert});
    endtask : test_downstream

    task automatic test_upstream();
        dn_mark(5'h01, 5'h00);
        cmp("disabled_sop", 8'h00, {7'h00, up_active});
        dn_mark(5'h06, 5'h00);
        cmp("up_select", 8'h02, {3'h0, up_select});
        cmp("up_active", 8'h01, {7'h00, up_active});
        cmp("up_invert", 8'h01, {7'h00, up_invert});
        cmp("up_fs_edge", 8'h01, {7'h00, up_fs_edge});
        cmp("up_no_down", 8'h00, {3'h0, dn_connect});
        dn_mark(5'h00, 5'h02);
        cmp("up_eop_select", 8'h00, {3'h0, up_select});
        cmp("up_eop_active", 8'h00, {7'h00, up_active});
        cmp("up_eop_edge", 8'h00, {7'h00, up_fs_edge});
    endtask : test_upstream

    task automatic test_descriptors();
        logic [7:0] lens  [5];
        logic [7:0] types [5];
        lens  = '{8'h12, 8'h09, 8'h09, 8'h07, 8'h09};
        types = '{hub_rep_pkg::TYPE_DEVICE, hub_rep_pkg::TYPE_CONFIG, hub_rep_pkg::TYPE_IFACE,
                  hub_rep_pkg::TYPE_ENDPT, hub_rep_pkg::TYPE_HUB};
        for (int k = 0; k < 5; k++) begin
            reg_write(8'h98, 8'(k));
            reg_write(8'h99, 8'h00);
            reg_read(8'h9A, rd_val);
            cmp("desc_length", lens[k], rd_val);
            reg_read(8'h9A, rd_val);
            cmp("desc_type", types[k], rd_val);
            if (k == 4) begin
                reg_read(8'h9A, rd_val);
                cmp("hub_nports", 8'h05, rd_val);
            end
            if (k == 1 || k == 2) begin
                reg_write(8'h99, 8'h04);
                reg_read(8'h9A, rd_val);
                cmp("one_iface_or_endpt", 8'h01, rd_val);
            end
        end
    endtask : test_descriptors

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn         = 1'b0;
        dn_sop         = 5'h00;
        dn_eop         = 5'h00;
        port_enabled   = 5'h1E;
        port_low_speed = 5'h03;
        tok_valid      = 1'b0;
        tok_addr       = 7'h00;
        reg_addr       = 8'h00;
        reg_wdata      = 8'h00;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        test_address();
        test_downstream();
        test_upstream();
        test_descriptors();
        give_verdict();
    end
endmodule : hub_repeater_connectivity_tb_top
